// [rtl/adr_pkg.sv]
// Package for the converter result readout: constants, timing figures and carriers
package adr_pkg;

  // Result word layout and counter widths
  localparam int RESULT_W = 16;
  localparam int OCTET_W = 8;
  localparam int OCTET_HI_MSB = 15;
  localparam int OCTET_HI_LSB = 8;
  localparam int OCTET_LO_MSB = 7;
  localparam int OCTET_LO_LSB = 0;
  localparam int SHIFT_CNT_W = 6;
  localparam int PULSE_CNT_W = 5;
  localparam int TIMER_W = 12;

  // Reset values and the straight binary MSB flip mask
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CODE_MSB_FLIP = 16'h8000;
  localparam logic [5:0] SHIFT_CNT_RESET = 6'h00;
  localparam logic [4:0] PULSES_RESET = 5'h00;
  localparam logic [11:0] TIMER_RESET = 12'h000;
  localparam logic [7:0] OCTET_RESET = 8'h00;

  // Clock rate and timing figures in their own units
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 20000;
  localparam int SHIFT_START_DELAY_NS = 2400;
  localparam int SHIFT_PERIOD_NS = 820;
  localparam int SHIFT_PULSES = 16;

  // Cycle counts: the longest time rounds down, least times round up
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int SHIFT_START_CYCLES = (SHIFT_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHIFT_HALF_CYCLES = (SHIFT_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [11:0] CONV_LAST = 12'(CONV_CYCLES - 1);
  localparam logic [11:0] SHIFT_START_LAST = 12'(SHIFT_START_CYCLES - 1);
  localparam logic [11:0] SHIFT_HALF_LAST = 12'(SHIFT_HALF_CYCLES - 1);
  localparam logic [4:0] SHIFT_PULSE_LAST = 5'(SHIFT_PULSES - 1);

  // Control pins as one synchronised group
  typedef struct packed {
    logic device_select_n;
    logic read_convert;
    logic half_select;
    logic code_format_select;
    logic shift_clock_source_select;
    logic daisy_chain_in;
  } adr_ctl_t;

  // Idle levels: not selected, read phase, upper half, two's complement, internal clock
  localparam adr_ctl_t CTL_RESET = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  // Conversion sequencer states, Gray coded along idle, convert, load
  typedef enum logic [1:0] {
    ADR_IDLE = 2'b00,
    ADR_CONV = 2'b01,
    ADR_LOAD = 2'b11
  } adr_state_t;

endpackage : adr_pkg

// [rtl/adr_readout.sv]
// Result readout of a 16-bit sampling converter: parallel octet bus and serial shift port
//
// Notes on behaviour
// - Format pin high gives straight binary, low gives two's complement, both ports.
// - Parallel reads leave the result alone; each internal pulse or enabled host edge shifts it one bit.
// - Internal clock mode: convert starts conversion, drives shift clock, sends previous result.
// - External clock mode: convert starts conversion, clock pin is input, internal timing converts.
// - External mode: after conversion completes, result shifts out with host clock.
// - External mode: during conversion, read combination shifts previous result with host clock.
// - While busy is low every convert command is ignored.
// - Octet bus driven only when read/convert high and select low; otherwise released.
// - Half select low gives upper eight bits, high gives lower eight bits.
// - Before the first completed conversion the parallel result is invalid.
// - At conversion end the result loads first, then busy rises.
// - Two's complement: 7fff, 0000, 8000; straight binary: ffff, 8000, 0000.
// - Internal mode emits sixteen pulses MSB first, then clock low, output takes tag.
// - Serial output is always driven, never released.
`timescale 1ns/10ps
`default_nettype none

module adr_readout (
  clk,
  rst,
  serial_shift_clock_in,
  device_select_n,
  read_convert,
  half_select,
  code_format_select,
  shift_clock_source_select,
  daisy_chain_in,
  sample_code,
  busy_n,
  result_valid,
  result_octet_bus_out,
  result_octet_bus_oe,
  serial_result_out,
  serial_shift_clock_out,
  serial_shift_clock_oe
);
  input wire logic clk;
  input wire logic rst;
  input wire logic serial_shift_clock_in;
  input wire logic device_select_n;
  input wire logic read_convert;
  input wire logic half_select;
  input wire logic code_format_select;
  input wire logic shift_clock_source_select;
  input wire logic daisy_chain_in;
  input wire logic [15:0] sample_code;
  output logic busy_n;
  output logic result_valid;
  output logic [7:0] result_octet_bus_out;
  output logic result_octet_bus_oe;
  output logic serial_result_out;
  output logic serial_shift_clock_out;
  output logic serial_shift_clock_oe;

  // Binary to Gray for the shift count crossing
  function automatic logic [5:0] adr_bin2gray(input logic [5:0] b);
    adr_bin2gray = b ^ (b >> 1);
  endfunction : adr_bin2gray

  // Gray to binary on the receiving side
  function automatic logic [5:0] adr_gray2bin(input logic [5:0] g);
    logic [5:0] b;
    b = '0;
    b[5] = g[5];
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    adr_gray2bin = b;
  endfunction : adr_gray2bin

  // Convert the core's two's complement code to the selected output format
  function automatic logic [15:0] adr_apply_format(input logic [15:0] code, input logic straight);
    adr_apply_format = straight ? (code ^ adr_pkg::CODE_MSB_FLIP) : code;
  endfunction : adr_apply_format

  adr_pkg::adr_ctl_t ctl_pins;
  adr_pkg::adr_ctl_t ctl_s1_reg;
  adr_pkg::adr_ctl_t ctl_s2_reg;
  adr_pkg::adr_state_t state_reg;
  logic [11:0] conv_cnt_reg;
  logic [15:0] held_code_reg;
  logic [15:0] result_reg;
  logic busy_n_reg;
  logic result_valid_reg;
  logic [7:0] octet_reg;
  logic octet_oe_reg;
  logic conv_req;
  logic conv_start;
  logic conv_done;
  logic int_run_reg;
  logic int_delay_reg;
  logic [11:0] int_tmr_reg;
  logic [4:0] int_pulses_reg;
  logic sclk_reg;
  logic sclk_oe_reg;
  logic tag_fill_reg;
  logic int_shift;
  logic [5:0] ext_cnt_reg;
  logic [5:0] ext_gray_reg;
  logic [5:0] gray_s1_reg;
  logic [5:0] gray_s2_reg;
  logic [5:0] ext_seen_reg;
  logic ext_pending;
  logic ext_enable;
  logic ext_shift;
  logic shift_fill;

  assign ctl_pins = '{device_select_n, read_convert, half_select, code_format_select,
                      shift_clock_source_select, daisy_chain_in};

  // Two-stage synchroniser for every control pin
  // The group moves together so a start sees one consistent set of levels
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_s1_reg <= adr_pkg::CTL_RESET;
      ctl_s2_reg <= adr_pkg::CTL_RESET;
    end else begin
      ctl_s1_reg <= ctl_pins;
      ctl_s2_reg <= ctl_s1_reg;
    end
  end

  // Select and read/convert are OR'ed and level sensitive; only idle accepts a start
  // Commands that arrive while busy or in the load cycle are dropped silently
  assign conv_req = !ctl_s2_reg.device_select_n && !ctl_s2_reg.read_convert;
  assign conv_start = (state_reg == adr_pkg::ADR_IDLE) && conv_req;
  assign conv_done = (state_reg == adr_pkg::ADR_CONV) && (conv_cnt_reg == adr_pkg::CONV_LAST);

  // Conversion sequencer, timed by the internal clock in both shift clock modes
  // The load state gives the result one cycle of set-up before busy rises
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= adr_pkg::ADR_IDLE;
      conv_cnt_reg <= adr_pkg::TIMER_RESET;
    end else begin
      unique case (state_reg)
        adr_pkg::ADR_IDLE: begin
          conv_cnt_reg <= adr_pkg::TIMER_RESET;
          if (conv_start) begin
            state_reg <= adr_pkg::ADR_CONV;
          end
        end
        adr_pkg::ADR_CONV: begin
          if (conv_done) begin
            state_reg <= adr_pkg::ADR_LOAD;
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 12'h001;
          end
        end
        adr_pkg::ADR_LOAD: begin
          state_reg <= adr_pkg::ADR_IDLE;
        end
        default: begin
          state_reg <= adr_pkg::ADR_IDLE;
        end
      endcase
    end
  end

  // Hold the core's code from the moment the conversion starts
  always_ff @(posedge clk) begin
    if (rst) begin
      held_code_reg <= adr_pkg::RESULT_RESET;
    end else if (conv_start) begin
      held_code_reg <= sample_code;
    end
  end

  // Busy falls at start and rises one cycle after the result register loads
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_n_reg <= 1'b1;
    end else if (conv_start) begin
      busy_n_reg <= 1'b0;
    end else if (state_reg == adr_pkg::ADR_LOAD) begin
      busy_n_reg <= 1'b1;
    end
  end

  // Marks that the result register holds a completed conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      result_valid_reg <= 1'b0;
    end else if (conv_done) begin
      result_valid_reg <= 1'b1;
    end
  end

  // Internal shift clock generator: start delay, then sixteen pulses, then low
  // The pulse count stops the generator after the last falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      int_run_reg <= 1'b0;
      int_delay_reg <= 1'b0;
      int_tmr_reg <= adr_pkg::TIMER_RESET;
      int_pulses_reg <= adr_pkg::PULSES_RESET;
      sclk_reg <= 1'b0;
    end else if (conv_start && !ctl_s2_reg.shift_clock_source_select) begin
      int_run_reg <= 1'b1;
      int_delay_reg <= 1'b1;
      int_tmr_reg <= adr_pkg::SHIFT_START_LAST;
      int_pulses_reg <= adr_pkg::PULSES_RESET;
      sclk_reg <= 1'b0;
    end else if (int_run_reg) begin
      if (int_tmr_reg != adr_pkg::TIMER_RESET) begin
        int_tmr_reg <= int_tmr_reg - 12'h001;
      end else if (int_delay_reg) begin
        int_delay_reg <= 1'b0;
        sclk_reg <= 1'b1;
        int_tmr_reg <= adr_pkg::SHIFT_HALF_LAST;
      end else if (sclk_reg) begin
        sclk_reg <= 1'b0;
        int_tmr_reg <= adr_pkg::SHIFT_HALF_LAST;
        int_pulses_reg <= int_pulses_reg + 5'h01;
        if (int_pulses_reg == adr_pkg::SHIFT_PULSE_LAST) begin
          int_run_reg <= 1'b0;
        end
      end else begin
        sclk_reg <= 1'b1;
        int_tmr_reg <= adr_pkg::SHIFT_HALF_LAST;
      end
    end
  end

  // A shift happens at the falling edge of each internal pulse
  // Bits change with the falling edge and hold while the clock is low, so the next rising edge finds them settled
  assign int_shift = int_run_reg && !int_delay_reg && sclk_reg && (int_tmr_reg == adr_pkg::TIMER_RESET);

  // Tag level seen as the first internal pulse rises fills the vacated bits
  always_ff @(posedge clk) begin
    if (rst) begin
      tag_fill_reg <= 1'b0;
    end else if (int_run_reg && int_delay_reg && (int_tmr_reg == adr_pkg::TIMER_RESET)) begin
      tag_fill_reg <= ctl_s2_reg.daisy_chain_in;
    end
  end

  // Shift clock pin drives out only while the internal source is selected
  // Reset leaves it driving low, matching the idle level of the internal clock
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_oe_reg <= 1'b1;
    end else begin
      sclk_oe_reg <= !ctl_s2_reg.shift_clock_source_select;
    end
  end

  // Link domain: a free count of host clock rising edges
  // The host clock may stand still through reset, so rst clears the count at once
  // instead of through a synchroniser that would need link edges to release it;
  // rst falls while the host clock idles, so no link edge meets the release
  // Count kept in binary and published in Gray so only one bit moves per edge
  always_ff @(posedge serial_shift_clock_in or posedge rst) begin
    if (rst) begin
      ext_cnt_reg <= adr_pkg::SHIFT_CNT_RESET;
      ext_gray_reg <= adr_pkg::SHIFT_CNT_RESET;
    end else begin
      ext_cnt_reg <= ext_cnt_reg + 6'h01;
      ext_gray_reg <= adr_bin2gray(ext_cnt_reg + 6'h01);
    end
  end

  // Gray count crosses into the converter domain through two flip-flops
  // A count caught mid-change is at worst one behind, never a wild value
  always_ff @(posedge clk) begin
    if (rst) begin
      gray_s1_reg <= adr_pkg::SHIFT_CNT_RESET;
      gray_s2_reg <= adr_pkg::SHIFT_CNT_RESET;
    end else begin
      gray_s1_reg <= ext_gray_reg;
      gray_s2_reg <= gray_s1_reg;
    end
  end

  // Host edges are consumed one per cycle; they shift only in the enabled read state
  assign ext_pending = adr_gray2bin(gray_s2_reg) != ext_seen_reg;
  assign ext_enable = ctl_s2_reg.shift_clock_source_select && !ctl_s2_reg.device_select_n &&
                      ctl_s2_reg.read_convert;
  assign ext_shift = ext_pending && ext_enable;

  // Consumed host edges; one per cycle whether or not shifting is enabled
  // Edges seen while disabled are used up here so they never shift later
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_seen_reg <= adr_gray2bin(gray_s2_reg);
    end else if (ext_pending) begin
      ext_seen_reg <= ext_seen_reg + 6'h01;
    end
  end

  // Internal mode fills with the captured tag, external mode with the present tag level
  assign shift_fill = ctl_s2_reg.shift_clock_source_select ? ctl_s2_reg.daisy_chain_in : tag_fill_reg;

  // The single result register: load on completion, shift on each internal pulse or enabled host edge
  // Load wins over a shift in the same cycle so a fresh result is never clipped
  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= adr_pkg::RESULT_RESET;
    end else if (conv_done) begin
      result_reg <= adr_apply_format(held_code_reg, ctl_s2_reg.code_format_select);
    end else if (int_shift || ext_shift) begin
      result_reg <= {result_reg[14:0], shift_fill};
    end
  end

  // Octet bus view of the result register; reading never disturbs it
  // The byte follows the register one cycle behind, the enable follows the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      octet_reg <= adr_pkg::OCTET_RESET;
      octet_oe_reg <= 1'b0;
    end else begin
      octet_oe_reg <= !ctl_s2_reg.device_select_n && ctl_s2_reg.read_convert;
      if (ctl_s2_reg.half_select) begin
        octet_reg <= result_reg[adr_pkg::OCTET_LO_MSB:adr_pkg::OCTET_LO_LSB];
      end else begin
        octet_reg <= result_reg[adr_pkg::OCTET_HI_MSB:adr_pkg::OCTET_HI_LSB];
      end
    end
  end

  // Outputs straight from flip-flops
  // The serial output is the register's top bit and is never released
  assign busy_n = busy_n_reg;
  assign result_valid = result_valid_reg;
  assign result_octet_bus_out = octet_reg;
  assign result_octet_bus_oe = octet_oe_reg;
  assign serial_result_out = result_reg[15];
  assign serial_shift_clock_out = sclk_reg;
  assign serial_shift_clock_oe = sclk_oe_reg;

endmodule : adr_readout

`default_nettype wire

// [test/adr_host_model.sv]
// Host partner model for the serial result port
`timescale 1ns/10ps
`default_nettype none

module adr_host_model (
  input wire logic burst_go,
  input wire logic shift_pin,
  input wire logic serial_result_out,
  output logic host_clk,
  output logic burst_done,
  output logic [15:0] ext_word,
  output logic [15:0] int_word
);
  // Host clock idles low between frames
  initial begin
    host_clk = 1'b0;
    burst_done = 1'b1;
    ext_word = 16'h0000;
    int_word = 16'h0000;
  end

  // Device clock: take the bit at each rise, MSB first
  always @(posedge shift_pin) begin
    int_word <= {int_word[14:0], serial_result_out};
  end

  // Sixteen pulses of a 30 ns host clock, each bit taken just before its rise
  always @(posedge burst_go) begin
    burst_done = 1'b0;
    #7;
    for (int i = 0; i < 16; i++) begin
      ext_word = {ext_word[14:0], serial_result_out};
      host_clk = 1'b1;
      #15;
      host_clk = 1'b0;
      #15;
    end
    burst_done = 1'b1;
  end
endmodule : adr_host_model
`default_nettype wire

// [test/adr_readout_props.sv]
// Checker for the converter result readout ports
`timescale 1ns/10ps
`default_nettype none

module adr_readout_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic device_select_n,
  input wire logic read_convert,
  input wire logic shift_clock_source_select,
  input wire logic busy_n,
  input wire logic result_valid,
  input wire logic result_octet_bus_oe,
  input wire logic serial_shift_clock_out,
  input wire logic serial_shift_clock_oe
);
  logic [11:0] low_cnt;
  logic [4:0] pulse_cnt;

  // Busy-low cycle count
  always_ff @(posedge clk) begin
    if (rst || busy_n) low_cnt <= 12'h000;
    else low_cnt <= low_cnt + 12'h001;
  end

  // Shift clock pulses since busy fell
  always_ff @(posedge clk) begin
    if (rst || $fell(busy_n)) pulse_cnt <= 5'h00;
    else if ($rose(serial_shift_clock_out)) pulse_cnt <= pulse_cnt + 5'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_bus_on; (!device_select_n && read_convert)[*4] |-> result_octet_bus_oe; endproperty
  a_bus_on: assert property (p_bus_on) else $error("octet bus not driven");
  property p_bus_off; (device_select_n || !read_convert)[*4] |-> !result_octet_bus_oe; endproperty
  a_bus_off: assert property (p_bus_off) else $error("octet bus driven");
  property p_busy_len; $rose(busy_n) |-> low_cnt == 12'h7d1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy low length wrong");
  property p_valid_load; $rose(result_valid) |-> !busy_n ##1 busy_n; endproperty
  a_valid_load: assert property (p_valid_load) else $error("busy not released after load");
  property p_clk_src; (!shift_clock_source_select)[*5] |-> serial_shift_clock_oe; endproperty
  a_clk_src: assert property (p_clk_src) else $error("shift clock not driven");
  property p_clk_idle; busy_n |-> !serial_shift_clock_out; endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("shift clock high while idle");
  property p_clk_high; $rose(serial_shift_clock_out) |-> ##40 serial_shift_clock_out ##1 !serial_shift_clock_out;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("shift clock high time wrong");
  property p_pulses; $rose(busy_n) |-> pulse_cnt == (serial_shift_clock_oe ? 5'h10 : 5'h00); endproperty
  a_pulses: assert property (p_pulses) else $error("shift pulse count wrong");
endmodule : adr_readout_props

bind adr_readout adr_readout_props u_props (.clk, .rst, .device_select_n, .read_convert,
  .shift_clock_source_select, .busy_n, .result_valid, .result_octet_bus_oe, .serial_shift_clock_out,
  .serial_shift_clock_oe);
`default_nettype wire

// [test/test_adr_readout.sv]
// Testbench for the converter result readout
`timescale 1ns/10ps
`default_nettype none

module test_adr_readout;
  logic clk, rst, device_select_n, read_convert, half_select, code_format_select;
  logic shift_clock_source_select, daisy_chain_in, burst_go, burst_done, host_clk, shift_pin;
  logic busy_n, result_valid, result_octet_bus_oe, serial_result_out, serial_shift_clock_out;
  logic serial_shift_clock_oe;
  logic [7:0] result_octet_bus_out;
  logic [15:0] sample_code, ext_word, int_word;
  int fails, n_compared;

  // Shared shift clock pin level
  assign shift_pin = serial_shift_clock_oe ? serial_shift_clock_out : host_clk;

  adr_readout dut_u (.clk(clk), .rst(rst), .serial_shift_clock_in(shift_pin), .device_select_n(device_select_n),
    .read_convert(read_convert), .half_select(half_select), .code_format_select(code_format_select),
    .shift_clock_source_select(shift_clock_source_select), .daisy_chain_in(daisy_chain_in),
    .sample_code(sample_code), .busy_n(busy_n), .result_valid(result_valid),
    .result_octet_bus_out(result_octet_bus_out), .result_octet_bus_oe(result_octet_bus_oe),
    .serial_result_out(serial_result_out), .serial_shift_clock_out(serial_shift_clock_out),
    .serial_shift_clock_oe(serial_shift_clock_oe));

  adr_host_model host_u (.burst_go(burst_go), .shift_pin(shift_pin), .serial_result_out(serial_result_out),
    .host_clk(host_clk), .burst_done(burst_done), .ext_word(ext_word), .int_word(int_word));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_busy(input logic lvl, input int lim);
    int i;
    i = 0;
    while (busy_n !== lvl && i < lim) begin
      @(posedge clk);
      i++;
    end
    if (busy_n !== lvl) begin
      fails++;
      summarize();
    end
  endtask : wait_busy

  // Start a conversion, release select, send a command that must be ignored, then release the pins
  task automatic start(input logic [15:0] code, input logic fmt, input logic src);
    @(posedge clk);
    sample_code <= code;
    code_format_select <= fmt;
    shift_clock_source_select <= src;
    device_select_n <= 1'b0;
    read_convert <= 1'b0;
    wait_busy(1'b0, 20);
    device_select_n <= 1'b1;
    repeat (3) @(posedge clk);
    device_select_n <= 1'b0;
    repeat (3) @(posedge clk);
    read_convert <= 1'b1;
    device_select_n <= 1'b1;
  endtask : start

  task automatic finish;
    wait_busy(1'b1, 2100);
  endtask : finish

  // Read both bytes, upper again, then release the bus
  task automatic read_par(input logic [15:0] exp);
    @(posedge clk);
    device_select_n <= 1'b0;
    half_select <= 1'b0;
    repeat (6) @(posedge clk);
    check(16'(result_octet_bus_oe), 16'h0001);
    check(16'(result_octet_bus_out), 16'(exp[15:8]));
    half_select <= 1'b1;
    repeat (6) @(posedge clk);
    check(16'(result_octet_bus_out), 16'(exp[7:0]));
    half_select <= 1'b0;
    repeat (6) @(posedge clk);
    check(16'(result_octet_bus_out), 16'(exp[15:8]));
    device_select_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(16'(result_octet_bus_oe), 16'h0000);
  endtask : read_par

  // Enable external shifting
  task automatic ser_on;
    @(posedge clk);
    device_select_n <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : ser_on

  task automatic burst;
    int i;
    i = 0;
    @(posedge clk);
    burst_go <= 1'b1;
    @(posedge clk);
    burst_go <= 1'b0;
    while (burst_done !== 1'b1 && i < 200) begin
      @(posedge clk);
      i++;
    end
    if (burst_done !== 1'b1) begin
      fails++;
      summarize();
    end
    repeat (8) @(posedge clk);
  endtask : burst

  // Output codes in both formats at the scale ends and midscale
  task automatic t_codes;
    logic [15:0] code [3];
    logic [15:0] sb [3];
    code = '{16'h7fff, 16'h0000, 16'h8000};
    sb = '{16'hffff, 16'h8000, 16'h0000};
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 3; k++) begin
        start(code[k], f[0], 1'b1);
        finish();
        check(16'(result_valid), 16'h0001);
        read_par(f[0] ? sb[k] : code[k]);
      end
    end
  endtask : t_codes

  // External clock: during and after a conversion, dropped frame, parallel copy lost
  task automatic t_ext;
    start(16'h1234, 1'b0, 1'b1);
    finish();
    start(16'h0ff0, 1'b0, 1'b1);
    ser_on();
    burst();
    check(ext_word, 16'h1234);
    finish();
    read_par(16'h0ff0);
    burst();
    ser_on();
    burst();
    check(ext_word, 16'h0ff0);
    read_par(16'hffff);
  endtask : t_ext

  // Internal clock: previous result out, then the tag level
  task automatic t_int;
    start(16'h3c96, 1'b0, 1'b0);
    finish();
    start(16'h0001, 1'b0, 1'b0);
    repeat (1700) @(posedge clk);
    check(16'(serial_result_out), 16'h0001);
    finish();
    check(int_word, 16'h3c96);
    read_par(16'h0001);
  endtask : t_int

  // Main sequence
  initial begin
    rst <= 1'b1;
    device_select_n = 1'b1;
    read_convert = 1'b1;
    half_select = 1'b0;
    code_format_select = 1'b0;
    shift_clock_source_select = 1'b1;
    daisy_chain_in = 1'b1;
    sample_code = 16'h0000;
    burst_go = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    check(16'({busy_n, result_valid, result_octet_bus_oe, serial_shift_clock_oe}), 16'h0009);
    check(16'(serial_result_out), 16'h0000);
    rst <= 1'b0;
    t_codes();
    t_ext();
    t_int();
    summarize();
  end
endmodule : test_adr_readout
`default_nettype wire
